// >>> sim/gpib_ctrl_model.sv
// Bus controller model: sends bytes and reads the talker with the three-wire handshake.
`timescale 1ns/1ps
module gpib_ctrl_model (
    input  wire logic                  sys_clk,
    input  wire gpib_pkg::bus_out_type bus_o,
    output gpib_pkg::bus_in_type       bus_i
);
    logic [7:0] c_dio = '0;
    logic       c_dav = '0, c_ndac = '0, c_atn = '0;
    // Wired-or of both parties; released lines fall back to the pulled-up idle level.
    assign bus_i = '{c_dio | (bus_o.dio_oe ? bus_o.dio : 8'h00), c_dav | bus_o.dav_oe, bus_o.nrfd_oe,
                     c_ndac | bus_o.ndac_oe, bus_o.eoi_oe, c_atn, 1'b0, 1'b1};
    // Source side: data is held until the device releases not-accepted.
    task automatic send(input logic a, input logic [7:0] b);
        @(posedge sys_clk);
        c_atn <= a;
        c_dio <= b;
        do @(posedge sys_clk); while (bus_o.nrfd_oe);
        c_dav <= '1;
        do @(posedge sys_clk); while (bus_o.ndac_oe);
        c_dav <= '0;
        c_dio <= '0;
    endtask
    // Acceptor side for one talker byte, as used by a serial poll.
    task automatic recv(output logic [7:0] b);
        c_atn <= '0;
        c_ndac <= '1;
        do @(posedge sys_clk); while (!bus_o.dav_oe);
        b = bus_o.dio;
        c_ndac <= '0;
        do @(posedge sys_clk); while (bus_o.dav_oe);
    endtask
endmodule

// >>> sim/gpib_instrument_interface_monitor.sv
// Port checker for the instrument bus interface.
`timescale 1ns/1ps
module gpib_instrument_interface_monitor (
    input wire logic                       sys_clk,
    input wire logic                       nrst,
    input wire gpib_pkg::bus_in_type       bus_i,
    input wire gpib_pkg::bus_out_type      bus_o,
    input wire logic                       error_event,
    input wire logic [gpib_pkg::KEY_W-1:0] keys,
    input wire logic                       lockout,
    input wire logic                       remote_led,
    input wire logic                       trig_hold,
    input wire logic                       dev_clear
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    // Request line tracks errors; it may only drop during an unattended poll byte.
    AST_SRQ_SET: assert property (error_event |=> bus_o.srq_oe) else $error("srq not raised");
    AST_SRQ_CLR: assert property ($fell(bus_o.srq_oe) |-> !bus_i.atn && !$past(error_event))
        else $error("srq dropped outside poll");
    // Keys stay dead for as long as remote lockout lasts.
    AST_LOCK_KEYS: assert property (lockout && remote_led && $past(lockout && remote_led) |-> keys == '0)
        else $error("keys live under lockout");
    AST_DCL_PULSE: assert property (dev_clear |=> !dev_clear) else $error("clear pulse too long");
    AST_DCL_TRIG: assert property (dev_clear |-> !trig_hold) else $error("trigger hold survives clear");
    // No parallel poll answer: data lines stay released under attention.
    AST_NO_PP: assert property (bus_i.atn [*2] |-> !bus_o.dio_oe) else $error("data driven under atn");
    AST_SETTLE: assert property ($rose(bus_o.dav_oe) |-> $past(bus_o.dio_oe, 8))
        else $error("data not settled before strobe");
    AST_READY: assert property ($rose(bus_o.dav_oe) |-> !$past(bus_i.nrfd)) else $error("strobe while not ready");
endmodule
bind gpib_instrument_interface gpib_instrument_interface_monitor i_mon (.*);

// >>> sim/tb_gpib_instrument_interface.sv
// Bench for addressing, lockout, clears, trigger and serial poll.
`timescale 1ns/1ps
module tb_gpib_instrument_interface;
    logic                  sys_clk = '0, nrst = '0, addr_wr = '0, error_event = '0;
    logic [4:0]            addr_val = '0, addr, a;
    logic [7:0]            keys_in = '0, keys, sb, rx_data;
    logic                  remote_led, lockout, trig_hold, rx_eom;
    int                    failures = 0, n_checks = 0, seed = 36316;
    gpib_pkg::bus_in_type  bus_i;
    gpib_pkg::bus_out_type bus_o;
    // Commands after a listen, with expected remote, lockout and trigger hold.
    logic [7:0]            cb [11] = '{8'h11, 8'h01, 8'h08, 8'h04, 8'h08, 8'h3f, 8'h04, 8'h08, 8'h14, 8'h05, 8'h15};
    logic [2:0]            ex [11] = '{3'h6, 3'h0, 3'h1, 3'h4, 3'h5, 3'h5, 3'h5, 3'h5, 3'h4, 3'h4, 3'h4};
    gpib_ctrl_model m (.sys_clk(sys_clk), .bus_o(bus_o), .bus_i(bus_i));
    gpib_instrument_interface i_dut (.sys_clk(sys_clk), .nrst(nrst), .bus_i(bus_i), .bus_o(bus_o),
        .addr_wr(addr_wr), .addr_val(addr_val), .addr(addr), .error_event(error_event), .rx_data(rx_data),
        .rx_valid(), .rx_eom(rx_eom), .rx_ready(1'b1), .tx_data(8'h00), .tx_last(1'b0), .tx_valid(1'b0),
        .tx_ready(), .keys_in(keys_in), .keys(keys), .remote_led(remote_led), .lockout(lockout),
        .trig_hold(trig_hold), .dev_clear());
    ////////////////////////////////////////////////////////////////
    // Status byte holds request and error bits only while an error waits.
    function automatic logic [7:0] stb(input logic e);
        return e ? 8'((1 << gpib_pkg::STB_RQS_BIT) | (1 << gpib_pkg::STB_ERR_BIT)) : 8'h00;
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Command effects land two edges after acceptance, so three edges is enough.
    task automatic cmd(input logic [7:0] b);
        m.send('1, b);
        repeat (3) @(posedge sys_clk);
    endtask
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // A full run needs well under a thousand cycles; this limit only catches a hang.
    initial begin
        #500000;
        failures++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        nrst <= '1;
        @(posedge sys_clk);
        chk("addr", 8'h01, {3'h0, addr});
        addr_wr <= '1;
        addr_val <= 5'($random(seed));
        keys_in <= 8'($random(seed)) | 8'h01;
        @(posedge sys_clk);
        addr_wr <= '0;
        a = addr_val <= 5'h1e ? addr_val : 5'h01;
        repeat (2) @(posedge sys_clk);
        chk("addr", {3'h0, a}, {3'h0, addr});
        cmd({3'b001, a});
        m.send('0, 8'h61);
        m.send('0, 8'h0a);
        @(posedge sys_clk);
        chk("rx_data", 8'h41, rx_data);
        chk("rx_eom", 8'h01, {7'h0, rx_eom});
        for (int i = 0; i < 11; i++) begin
            cmd(cb[i]);
            chk("mode", {5'h0, ex[i]}, {5'h0, remote_led, lockout, trig_hold});
            chk("keys", ex[i][1] ? 8'h00 : keys_in, keys);
        end
        // Poll once with an error pending, then once without.
        for (int e = 1; e >= 0; e--) begin
            error_event <= e[0];
            @(posedge sys_clk);
            error_event <= '0;
            repeat (2) @(posedge sys_clk);
            chk("srq", {7'h0, e[0]}, {7'h0, bus_o.srq_oe});
            cmd(8'h18);
            cmd({3'b010, a});
            m.recv(sb);
            cmd(8'h19);
            chk("status", stb(e[0]), sb);
            chk("srq", 8'h00, {7'h0, bus_o.srq_oe});
        end
        wrap_up();
    end
endmodule

// >>> verilog/gpib_accept_hs.sv
// Three-wire acceptor handshake: takes one byte per data-valid strobe.
`timescale 1ns/1ps
module gpib_accept_hs (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       enable,
    input  wire logic       hold_off,
    input  wire logic       dav,
    input  wire logic [7:0] dio,
    input  wire logic       atn,
    input  wire logic       eoi,
    output logic            valid,
    output logic [7:0]      data,
    output logic            is_cmd,
    output logic            is_end,
    output logic            nrfd,
    output logic            ndac,
    output logic            active
);

    typedef struct packed {
        gpib_pkg::ah_state_type state;
        logic [7:0]             data;
        logic                   is_cmd;
        logic                   is_end;
        logic                   valid;
    } ah_type;

    ah_type st;
    ah_type next_st;

    // Accept once per strobe, then wait for the strobe to drop before readying again.
    always_comb begin
        next_st       = st;
        next_st.valid = 1'b0;
        case (st.state)
            gpib_pkg::AH_READY: begin
                if (dav && (atn || !hold_off)) begin
                    next_st.state  = gpib_pkg::AH_ACCEPT;
                    next_st.data   = dio;
                    next_st.is_cmd = atn;
                    next_st.is_end = eoi;
                    next_st.valid  = 1'b1;
                end
            end
            gpib_pkg::AH_ACCEPT: next_st.state = gpib_pkg::AH_HOLD;
            gpib_pkg::AH_HOLD: begin
                if (!dav) begin
                    next_st.state = gpib_pkg::AH_READY;
                end
            end
            default: next_st.state = gpib_pkg::AH_READY;
        endcase
        if (!enable) begin
            next_st.state = gpib_pkg::AH_READY;
            next_st.valid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Not ready while busy or holding; accepted is withheld until a byte is taken.
    assign nrfd   = (st.state != gpib_pkg::AH_READY) || (hold_off && !atn);
    assign ndac   = (st.state == gpib_pkg::AH_READY);
    assign active = enable;
    assign valid  = st.valid;
    assign data   = st.data;
    assign is_cmd = st.is_cmd;
    assign is_end = st.is_end;

endmodule

// >>> verilog/gpib_instrument_interface.sv
// Device-side instrument bus interface: addressing, remote/local, clears, trigger and polling.
//
// Functional notes
// - Full three-wire handshake, both directions.
// - Talker with serial poll; own listen unaddresses.
// - Listener; own talk address unaddresses it.
// - Full remote/local handling including lockout.
// - No parallel poll; configure and poll ignored.
// - Universal and addressed device clear supported.
// - Group trigger acted on when addressed listener.
// - Address 0 to 30, factory value 1.
// - Service request asserted on any error.
// - Serial poll clears the pending error.
// - Status byte zero unless error pending.
// - Lockout in remote blocks front panel keys.
// - Go-to-local when listening leaves remote, lifts lockout.
// - Remote lamp on first message until go-to-local or disengage.
// - Serial port neither touches nor feels bus.
// - Universal clear empties buffers, resets, goes remote.
// - Selected clear only when listening, then remote.
// - Trigger freezes bus reading until read.
// - Interface clear aborts and idles interface.
// - Line feed ends messages, carriage return optional.
// - Letters are case-insensitive in message text.
`timescale 1ns/1ps
module gpib_instrument_interface (
    input  wire logic                       sys_clk,
    input  wire logic                       nrst,
    input  wire gpib_pkg::bus_in_type       bus_i,
    output gpib_pkg::bus_out_type           bus_o,
    input  wire logic                       addr_wr,
    input  wire logic [4:0]                 addr_val,
    output logic [4:0]                      addr,
    input  wire logic                       error_event,
    output logic [7:0]                      rx_data,
    output logic                            rx_valid,
    output logic                            rx_eom,
    input  wire logic                       rx_ready,
    input  wire logic [7:0]                 tx_data,
    input  wire logic                       tx_last,
    input  wire logic                       tx_valid,
    output logic                            tx_ready,
    input  wire logic [gpib_pkg::KEY_W-1:0] keys_in,
    output logic [gpib_pkg::KEY_W-1:0]      keys,
    output logic                            remote_led,
    output logic                            lockout,
    output logic                            trig_hold,
    output logic                            dev_clear
);

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        logic [4:0]                 addr;
        logic                       talk;
        logic                       listen;
        logic                       spe;
        logic                       stb_sent;
        logic                       remote;
        logic                       llo;
        logic                       err;
        logic                       rqs;
        logic                       trig_hold;
        logic [7:0]                 rx_data;
        logic                       rx_valid;
        logic                       rx_eom;
        logic                       dev_clear;
        logic [gpib_pkg::KEY_W-1:0] keys;
    } iface_type;

    iface_type st;
    iface_type next_st;

    logic       ah_valid;
    logic [7:0] ah_data;
    logic       ah_cmd;
    logic       ah_end;
    logic       ah_nrfd;
    logic       ah_ndac;
    logic       ah_active;
    logic       ah_enable;
    logic       sh_busy;
    logic       sh_done;
    logic       sh_dav;
    logic       sh_drive;
    logic [7:0] sh_dio;
    logic       sh_eoi;
    logic       sh_start;
    logic       sh_abort;
    logic [7:0] sh_byte;
    logic       sh_last;
    logic [7:0] status_byte;
    logic [6:0] cmd;
    logic       my_listen;
    logic       my_talk;
    logic [7:0] text_byte;

    ////////////////////////////////////////////////////////////////////////////////
    // Handshake engines.

    // Commands are taken whenever attention is asserted and interface clear is not; data only when listening.
    assign ah_enable = !bus_i.ifc && (bus_i.atn || st.listen);

    gpib_accept_hs u_accept (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .enable   (ah_enable),
        .hold_off (!rx_ready),
        .dav      (bus_i.dav),
        .dio      (bus_i.dio),
        .atn      (bus_i.atn),
        .eoi      (bus_i.eoi),
        .valid    (ah_valid),
        .data     (ah_data),
        .is_cmd   (ah_cmd),
        .is_end   (ah_end),
        .nrfd     (ah_nrfd),
        .ndac     (ah_ndac),
        .active   (ah_active)
    );

    // Status byte carries only request and error, so it reads zero with no error.
    always_comb begin
        status_byte                       = 8'h00;
        status_byte[gpib_pkg::STB_RQS_BIT] = st.rqs;
        status_byte[gpib_pkg::STB_ERR_BIT] = st.err;
    end

    // In serial poll mode the talker sends one status byte per poll instead of data.
    assign sh_byte  = st.spe ? status_byte : tx_data;
    assign sh_last  = st.spe ? 1'b0 : tx_last;
    assign sh_start = st.talk && !bus_i.atn && !sh_busy && !sh_done &&
                      (st.spe ? !st.stb_sent : tx_valid);
    // Any loss of the talker role or attention from the controller aborts the byte.
    assign sh_abort = bus_i.ifc || bus_i.atn || !st.talk || st.dev_clear;

    gpib_source_hs u_source (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .abort   (sh_abort),
        .start   (sh_start),
        .data    (sh_byte),
        .last    (sh_last),
        .nrfd    (bus_i.nrfd),
        .ndac    (bus_i.ndac),
        .busy    (sh_busy),
        .done    (sh_done),
        .dav     (sh_dav),
        .drive   (sh_drive),
        .dio     (sh_dio),
        .eoi     (sh_eoi)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode helpers.

    assign cmd       = ah_data[6:0];
    assign my_listen = (cmd[6:5] == gpib_pkg::GRP_LISTEN) && (cmd[4:0] == st.addr);
    assign my_talk   = (cmd[6:5] == gpib_pkg::GRP_TALK) && (cmd[4:0] == st.addr);

    // Lower-case letters are folded to upper case so the parser sees one form.
    always_comb begin
        text_byte = ah_data;
        if (ah_data >= gpib_pkg::CHAR_LOW_A && ah_data <= gpib_pkg::CHAR_LOW_Z) begin
            text_byte[gpib_pkg::CASE_BIT] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interface state update.

    always_comb begin
        next_st           = st;
        next_st.rx_valid  = 1'b0;
        next_st.rx_eom    = 1'b0;
        next_st.dev_clear = 1'b0;

        // Address changes outside 0..30 are refused and the old address kept.
        if (addr_wr && addr_val <= gpib_pkg::ADDR_MAX) begin
            next_st.addr = addr_val;
        end

        // A new poll may follow once the controller takes attention again.
        if (bus_i.atn) begin
            next_st.stb_sent = 1'b0;
        end

        // Interface commands, taken while attention is asserted.
        if (ah_valid && ah_cmd) begin
            case (cmd[6:5])
                gpib_pkg::GRP_LISTEN: begin
                    if (cmd[4:0] == gpib_pkg::ADDR_UNADDR) begin
                        next_st.listen = 1'b0;
                    end else if (my_listen) begin
                        next_st.listen = 1'b1;
                        next_st.talk   = 1'b0;
                        // First contact from a controller holding remote enable lights remote.
                        if (bus_i.ren) begin
                            next_st.remote = 1'b1;
                        end
                    end
                end
                gpib_pkg::GRP_TALK: begin
                    if (my_talk) begin
                        next_st.talk   = 1'b1;
                        next_st.listen = 1'b0;
                        if (bus_i.ren) begin
                            next_st.remote = 1'b1;
                        end
                    end else begin
                        next_st.talk = 1'b0;
                    end
                end
                gpib_pkg::GRP_CMD: begin
                    case (cmd)
                        gpib_pkg::CMD_GTL: begin
                            if (st.listen) begin
                                next_st.remote = 1'b0;
                                next_st.llo    = 1'b0;
                            end
                        end
                        gpib_pkg::CMD_LLO: begin
                            if (bus_i.ren) begin
                                next_st.llo = 1'b1;
                            end
                        end
                        gpib_pkg::CMD_DCL: begin
                            next_st.dev_clear = 1'b1;
                            next_st.trig_hold = 1'b0;
                            next_st.remote    = bus_i.ren;
                        end
                        gpib_pkg::CMD_SDC: begin
                            if (st.listen) begin
                                next_st.dev_clear = 1'b1;
                                next_st.trig_hold = 1'b0;
                                next_st.remote    = bus_i.ren;
                            end
                        end
                        gpib_pkg::CMD_GET: begin
                            if (st.listen) begin
                                next_st.trig_hold = 1'b1;
                            end
                        end
                        gpib_pkg::CMD_SPE: next_st.spe = 1'b1;
                        gpib_pkg::CMD_SPD: next_st.spe = 1'b0;
                        // No parallel poll response exists, so configuration is dropped.
                        gpib_pkg::CMD_PPC: next_st.spe = st.spe;
                        gpib_pkg::CMD_PPU: next_st.spe = st.spe;
                        default:           next_st.spe = st.spe;
                    endcase
                end
                default: next_st.talk = st.talk;
            endcase
        end

        // Message text, taken only as a listener; carriage return is dropped so either
        // ending form reaches the parser as one end-of-message pulse.
        if (ah_valid && !ah_cmd && st.listen) begin
            if (bus_i.ren) begin
                next_st.remote = 1'b1;
            end
            if (ah_data == gpib_pkg::CHAR_LF) begin
                next_st.rx_eom = 1'b1;
            end else if (ah_data != gpib_pkg::CHAR_CR) begin
                next_st.rx_data  = text_byte;
                next_st.rx_valid = 1'b1;
                next_st.rx_eom   = ah_end;
            end
        end

        // The frozen reading is released once its last byte has been read.
        if (sh_done && !st.spe && sh_last) begin
            next_st.trig_hold = 1'b0;
        end

        // A status byte taken by the controller clears the error and drops the request.
        if (sh_done && st.spe) begin
            next_st.stb_sent = 1'b1;
            next_st.err      = 1'b0;
            next_st.rqs      = 1'b0;
        end
        // A fresh error wins over a clear in the same cycle.
        if (error_event) begin
            next_st.err = 1'b1;
            next_st.rqs = 1'b1;
        end

        // Remote enable released means the controller has disengaged.
        if (!bus_i.ren) begin
            next_st.remote = 1'b0;
            next_st.llo    = 1'b0;
        end

        // Interface clear returns talker, listener and poll mode to idle.
        if (bus_i.ifc) begin
            next_st.talk   = 1'b0;
            next_st.listen = 1'b0;
            next_st.spe    = 1'b0;
        end

        // Keys pass only when lockout is not in effect in remote mode.
        next_st.keys = (st.remote && st.llo) ? '0 : keys_in;
    end

    // Address comes up at its factory value; bus state comes up idle and local.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st      <= '0;
            st.addr <= gpib_pkg::ADDR_RESET;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    // Serial-port traffic has no path into this block, so it cannot reach the lamp.
    assign remote_led = st.remote;
    assign lockout    = st.remote && st.llo;
    assign keys       = st.keys;
    assign addr       = st.addr;
    assign trig_hold  = st.trig_hold;
    assign dev_clear  = st.dev_clear;
    assign rx_data    = st.rx_data;
    assign rx_valid   = st.rx_valid;
    assign rx_eom     = st.rx_eom;
    assign tx_ready   = sh_done && !st.spe;

    // Open-drain lines are enabled only while asserted; data lines only while talking.
    always_comb begin
        bus_o         = '0;
        bus_o.dio     = sh_dio;
        bus_o.dio_oe  = sh_drive;
        bus_o.dav     = sh_dav;
        bus_o.dav_oe  = sh_dav;
        bus_o.eoi     = sh_eoi;
        bus_o.eoi_oe  = sh_eoi;
        bus_o.nrfd    = ah_active && ah_nrfd;
        bus_o.nrfd_oe = ah_active && ah_nrfd;
        bus_o.ndac    = ah_active && ah_ndac;
        bus_o.ndac_oe = ah_active && ah_ndac;
        bus_o.srq     = st.rqs;
        bus_o.srq_oe  = st.rqs;
    end

endmodule

// >>> verilog/gpib_pkg.sv
// Shared constants, bus carriers and state types for the instrument bus interface.
package gpib_pkg;

    // Clock and handshake timing.
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_NS     = 2000;
    // Data settle time before the data-valid strobe; a least time, so it rounds up.
    localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W      = 8;
    localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(SETTLE_CYCLES - 1);

    // Bus address range and factory value.
    localparam logic [4:0] ADDR_RESET = 5'h01;
    localparam logic [4:0] ADDR_MAX   = 5'h1e;
    localparam logic [4:0] ADDR_UNADDR = 5'h1f;

    // Command byte groups (bits 6:5) and universal or addressed commands.
    localparam logic [1:0] GRP_CMD    = 2'h0;
    localparam logic [1:0] GRP_LISTEN = 2'h1;
    localparam logic [1:0] GRP_TALK   = 2'h2;
    localparam logic [6:0] CMD_GTL = 7'h01;
    localparam logic [6:0] CMD_SDC = 7'h04;
    localparam logic [6:0] CMD_PPC = 7'h05;
    localparam logic [6:0] CMD_GET = 7'h08;
    localparam logic [6:0] CMD_LLO = 7'h11;
    localparam logic [6:0] CMD_DCL = 7'h14;
    localparam logic [6:0] CMD_PPU = 7'h15;
    localparam logic [6:0] CMD_SPE = 7'h18;
    localparam logic [6:0] CMD_SPD = 7'h19;

    // Status byte layout.
    localparam int STB_RQS_BIT = 6;
    localparam int STB_ERR_BIT = 0;

    // Text handling.
    localparam logic [7:0] CHAR_LF    = 8'h0a;
    localparam logic [7:0] CHAR_CR    = 8'h0d;
    localparam logic [7:0] CHAR_LOW_A = 8'h61;
    localparam logic [7:0] CHAR_LOW_Z = 8'h7a;
    localparam int         CASE_BIT   = 5;

    localparam int KEY_W = 8;

    // Bus lines as seen by the device; 1 means the line is asserted (electrically low).
    typedef struct packed {
        logic [7:0] dio;
        logic       dav;
        logic       nrfd;
        logic       ndac;
        logic       eoi;
        logic       atn;
        logic       ifc;
        logic       ren;
    } bus_in_type;

    // Driven lines: value plus enable, enable high while the device drives the line.
    typedef struct packed {
        logic [7:0] dio;
        logic       dio_oe;
        logic       dav;
        logic       dav_oe;
        logic       eoi;
        logic       eoi_oe;
        logic       nrfd;
        logic       nrfd_oe;
        logic       ndac;
        logic       ndac_oe;
        logic       srq;
        logic       srq_oe;
    } bus_out_type;

    typedef enum logic [1:0] {
        SH_IDLE   = 2'b00,
        SH_SETTLE = 2'b01,
        SH_VALID  = 2'b11
    } sh_state_type;

    typedef enum logic [1:0] {
        AH_READY  = 2'b00,
        AH_ACCEPT = 2'b01,
        AH_HOLD   = 2'b11
    } ah_state_type;

endpackage

// >>> verilog/gpib_source_hs.sv
// Three-wire source handshake: drives one byte per start onto the bus.
`timescale 1ns/1ps
module gpib_source_hs (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       abort,
    input  wire logic       start,
    input  wire logic [7:0] data,
    input  wire logic       last,
    input  wire logic       nrfd,
    input  wire logic       ndac,
    output logic            busy,
    output logic            done,
    output logic            dav,
    output logic            drive,
    output logic [7:0]      dio,
    output logic            eoi
);

    typedef struct packed {
        gpib_pkg::sh_state_type         state;
        logic [gpib_pkg::SETTLE_W-1:0]  cnt;
        logic [7:0]                     data;
        logic                           last;
        logic                           done;
    } sh_type;

    sh_type st;
    sh_type next_st;

    // Byte is latched at start so the sender may change its data once done pulses.
    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        case (st.state)
            gpib_pkg::SH_IDLE: begin
                if (start) begin
                    next_st.state = gpib_pkg::SH_SETTLE;
                    next_st.cnt   = gpib_pkg::SETTLE_LOAD;
                    next_st.data  = data;
                    next_st.last  = last;
                end
            end
            gpib_pkg::SH_SETTLE: begin
                // Strobe only after settling and once every acceptor is ready.
                if (st.cnt != '0) begin
                    next_st.cnt = st.cnt - 1'b1;
                end else if (!nrfd) begin
                    next_st.state = gpib_pkg::SH_VALID;
                end
            end
            gpib_pkg::SH_VALID: begin
                if (!ndac) begin
                    next_st.state = gpib_pkg::SH_IDLE;
                    next_st.done  = 1'b1;
                end
            end
            default: next_st.state = gpib_pkg::SH_IDLE;
        endcase
        if (abort) begin
            next_st.state = gpib_pkg::SH_IDLE;
            next_st.done  = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign busy  = (st.state != gpib_pkg::SH_IDLE);
    assign done  = st.done;
    assign dav   = (st.state == gpib_pkg::SH_VALID);
    assign drive = busy;
    assign dio   = st.data;
    assign eoi   = busy && st.last;

endmodule
